// >>> mbap_bus.sv
`timescale 1ns/10ps
// Operation
// - address cycle: word address, count code
// - count code 00..11 means 1..4
// - write data drives every lane definitely
// - halt after write: last data bits 31:2 shown
// - halt after read: address, last low bits
// - halt shows last count code
// - latch strobe high only in address cycle
// - inverted latch strobe always mirrors it
// - start strobe low for address cycle
// - 32-bit: word address steps per ready
// - 16-bit: halfword address steps per ready
// - 8-bit: byte address steps per ready
// - reset: strobes inactive, bus driven
// - hold: bus and strobes float
// - halt: strobes inactive, bus kept
// - missing ready inserts a wait cycle
// - 8/16-bit: byte enable pins carry low address
// - direction set in address cycle, held
module mbap_bus (
    input  wire logic         mclk,
    input  wire logic         rstn,
    // request side (same clock)
    input  wire logic         req_valid,
    output logic              req_ready,
    input  wire logic [31:0]  req_addr,
    input  wire logic         req_write,
    input  wire logic [1:0]   req_size,
    input  wire logic [1:0]   req_width,
    input  wire logic [3:0]   req_be_n,
    input  wire logic [127:0] req_wdata,
    input  wire logic         halt_req,
    output logic              halted,
    // read data side
    output logic              rd_valid,
    input  wire logic         rd_ready,
    output logic [31:0]       rd_data,
    output logic              rd_last,
    // pins
    output logic [31:0]       ad_out,
    input  wire logic [31:0]  ad_in,
    output logic              ad_oe_n,
    output logic              addr_latch,
    output logic              addr_latch_n,
    output logic              access_start_strobe_n,
    output logic              strobe_oe_n,
    output logic [3:2]        addr_lo,
    output logic [3:0]        byte_lane_enables_n,
    output logic              write_read,
    input  wire logic         ready_recover_n,
    input  wire logic         hold_req,
    output logic              hold_ack,
    output logic              wait_cycle
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    mbap_pkg::mbap_state_t state_r;
    mbap_pkg::mbap_state_t state_nxt;

    logic [31:0]  ad_in_m_r;
    logic [31:0]  ad_in_s_r;
    logic         rdy_m_r;
    logic         rdy_s_r;
    logic         hold_m_r;
    logic         hold_s_r;

    logic [31:0]  addr_r;
    logic         wr_r;
    logic [1:0]   size_r;
    logic [127:0] wdata_r;
    logic [1:0]   beat_r;
    logic [1:0]   beat_nxt;

    logic         last_wr_r;
    logic [31:0]  last_addr_r;
    logic [1:0]   last_size_r;
    logic [31:0]  last_wdata_r;
    logic [3:2]   last_lo_r;

    logic         take;
    logic         xfer;
    logic         last_beat;
    logic         buf_in_ready;

    mbap_step_if  st ();

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] word_sel(input logic [127:0] d, input logic [1:0] b);
        word_sel = d[b*mbap_pkg::WORD_W +: mbap_pkg::WORD_W];
    endfunction : word_sel

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    // two flops on every pin input; only the second stage is read
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ad_in_m_r <= mbap_pkg::AD_RST;
            ad_in_s_r <= mbap_pkg::AD_RST;
            rdy_m_r   <= 1'b0;
            rdy_s_r   <= 1'b0;
            hold_m_r  <= 1'b0;
            hold_s_r  <= 1'b0;
        end else begin
            ad_in_m_r <= ad_in;
            ad_in_s_r <= ad_in_m_r;
            rdy_m_r   <= !ready_recover_n;
            rdy_s_r   <= rdy_m_r;
            hold_m_r  <= hold_req;
            hold_s_r  <= hold_m_r;
        end
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // a stalled read buffer holds off the transfer like a missing ready
    assign take      = (state_r == mbap_pkg::MBAP_IDLE) && req_valid && req_ready;
    assign xfer      = (state_r == mbap_pkg::MBAP_DATA) && rdy_s_r
                       && (wr_r || buf_in_ready);
    assign last_beat = (beat_r == size_r);

    // pending request wins over hold and halt so the handshake stays honest
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            mbap_pkg::MBAP_IDLE: begin
                if (take) begin
                    state_nxt = mbap_pkg::MBAP_ADDR;
                end else if (hold_s_r) begin
                    state_nxt = mbap_pkg::MBAP_HOLD;
                end else if (halt_req) begin
                    state_nxt = mbap_pkg::MBAP_HALT;
                end
            end
            mbap_pkg::MBAP_ADDR: begin
                state_nxt = mbap_pkg::MBAP_DATA;
            end
            mbap_pkg::MBAP_DATA: begin
                if (xfer && last_beat) begin
                    state_nxt = mbap_pkg::MBAP_IDLE;
                end
            end
            mbap_pkg::MBAP_HOLD: begin
                if (!hold_s_r) begin
                    state_nxt = halt_req ? mbap_pkg::MBAP_HALT : mbap_pkg::MBAP_IDLE;
                end
            end
            mbap_pkg::MBAP_HALT: begin
                if (hold_s_r) begin
                    state_nxt = mbap_pkg::MBAP_HOLD;
                end else if (!halt_req) begin
                    state_nxt = mbap_pkg::MBAP_IDLE;
                end
            end
            default: begin
                state_nxt = mbap_pkg::MBAP_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_r <= mbap_pkg::MBAP_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // beat counter: restarts in the address cycle, advances per ready
    always_comb begin
        beat_nxt = beat_r;
        if (state_r == mbap_pkg::MBAP_ADDR) begin
            beat_nxt = 2'h0;
        end else if (xfer) begin
            beat_nxt = beat_r + 2'h1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            beat_r <= 2'h0;
        end else begin
            beat_r <= beat_nxt;
        end
    end

    // request ready only when the sequencer will be idle next cycle
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= (state_nxt == mbap_pkg::MBAP_IDLE) && !take;
        end
    end

    // ----------------------------------------------------------------
    // access capture and halt history
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            addr_r     <= mbap_pkg::AD_RST;
            wr_r       <= 1'b0;
            size_r     <= mbap_pkg::SIZE_ONE;
            wdata_r    <= 128'h0;
            write_read <= 1'b0;
        end else if (take) begin
            addr_r     <= req_addr;
            wr_r       <= req_write;
            size_r     <= req_size;
            wdata_r    <= req_wdata;
            write_read <= req_write;
        end
    end

    // what the bus last carried, replayed when the core halts
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            last_wr_r    <= 1'b0;
            last_addr_r  <= mbap_pkg::AD_RST;
            last_size_r  <= mbap_pkg::SIZE_ONE;
            last_wdata_r <= mbap_pkg::AD_RST;
            last_lo_r    <= 2'h0;
        end else if (xfer) begin
            last_wr_r    <= wr_r;
            last_addr_r  <= addr_r;
            last_size_r  <= size_r;
            last_wdata_r <= word_sel(wdata_r, beat_r);
            last_lo_r    <= st.lo[3:2];
        end
    end

    // ----------------------------------------------------------------
    // shared address/data bus
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ad_out  <= mbap_pkg::AD_RST;
            ad_oe_n <= 1'b0;
        end else begin
            case (state_nxt)
                mbap_pkg::MBAP_ADDR: begin
                    ad_out  <= {req_addr[mbap_pkg::ADDR_HI:mbap_pkg::ADDR_WORD_LO],
                                req_size};
                    ad_oe_n <= 1'b0;
                end
                mbap_pkg::MBAP_DATA: begin
                    if (wr_r) begin
                        ad_out <= word_sel(wdata_r, beat_nxt);
                    end
                    ad_oe_n <= !wr_r;
                end
                mbap_pkg::MBAP_HALT: begin
                    if (state_r != mbap_pkg::MBAP_HALT) begin
                        if (last_wr_r) begin
                            ad_out <= {last_wdata_r[mbap_pkg::ADDR_HI:mbap_pkg::ADDR_WORD_LO],
                                       last_size_r};
                        end else begin
                            ad_out <= {last_addr_r[mbap_pkg::ADDR_HI:mbap_pkg::ADDR_HALT_LO],
                                       last_lo_r, last_size_r};
                        end
                    end
                    ad_oe_n <= 1'b0;
                end
                mbap_pkg::MBAP_HOLD: begin
                    ad_oe_n <= 1'b1;
                end
                default: begin
                    ad_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // strobes and status pins
    // ----------------------------------------------------------------
    // both latch strobes come from one decode so they never disagree
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            addr_latch            <= 1'b0;
            addr_latch_n          <= 1'b1;
            access_start_strobe_n <= 1'b1;
        end else begin
            addr_latch            <= (state_nxt == mbap_pkg::MBAP_ADDR);
            addr_latch_n          <= (state_nxt != mbap_pkg::MBAP_ADDR);
            access_start_strobe_n <= (state_nxt != mbap_pkg::MBAP_ADDR);
        end
    end

    // the strobes float via strobe_oe_n while another master owns the bus
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            strobe_oe_n <= 1'b0;
            hold_ack    <= 1'b0;
            halted      <= 1'b0;
            wait_cycle  <= 1'b0;
        end else begin
            strobe_oe_n <= (state_nxt == mbap_pkg::MBAP_HOLD);
            hold_ack    <= (state_nxt == mbap_pkg::MBAP_HOLD);
            halted      <= (state_nxt == mbap_pkg::MBAP_HALT);
            wait_cycle  <= (state_r == mbap_pkg::MBAP_DATA) && !xfer;
        end
    end

    // ----------------------------------------------------------------
    // partial demultiplexed address
    // ----------------------------------------------------------------
    assign st.load     = take;
    assign st.step     = xfer && !last_beat;
    assign st.park     = (state_nxt == mbap_pkg::MBAP_HALT) && (state_r != mbap_pkg::MBAP_HALT);
    assign st.width    = req_width;
    assign st.start_lo = req_addr[3:0];
    assign st.req_be_n = req_be_n;

    mbap_burst_lo u_lo (
        .mclk (mclk),
        .rstn (rstn),
        .st   (st.gen)
    );

    // low pins are flops inside the stepper; addr_lo held across halt, byte enables parked high
    assign addr_lo             = st.lo[3:2];
    assign byte_lane_enables_n = st.be_n;

    // ----------------------------------------------------------------
    // read data buffer
    // ----------------------------------------------------------------
    // a full buffer stalls the data cycle so no word is lost
    mbap_buf2 u_rbuf (
        .mclk      (mclk),
        .rstn      (rstn),
        .in_valid  (xfer && !wr_r),
        .in_ready  (buf_in_ready),
        .in_data   ({last_beat, ad_in_s_r}),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  ({rd_last, rd_data})
    );
endmodule : mbap_bus

// >>> mbap_pkg.sv
package mbap_pkg;

    // ----------------------------------------------------------------
    // bus sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MBAP_IDLE,
        MBAP_ADDR,
        MBAP_DATA,
        MBAP_HOLD,
        MBAP_HALT
    } mbap_state_t;

    // ----------------------------------------------------------------
    // region width codes and transfer-count codes
    // ----------------------------------------------------------------
    localparam logic [1:0] WIDTH_8      = 2'h0;
    localparam logic [1:0] WIDTH_16     = 2'h1;
    localparam logic [1:0] WIDTH_32     = 2'h2;
    localparam logic [1:0] SIZE_ONE     = 2'h0;
    localparam logic [1:0] SIZE_TWO     = 2'h1;
    localparam logic [1:0] SIZE_THREE   = 2'h2;
    localparam logic [1:0] SIZE_FOUR    = 2'h3;

    // ----------------------------------------------------------------
    // field positions on the shared bus
    // ----------------------------------------------------------------
    localparam int ADDR_HI      = 31;
    localparam int ADDR_WORD_LO = 2;
    localparam int ADDR_HALT_LO = 4;
    localparam int WORD_W       = 32;
    localparam int BEATS        = 4;
    localparam int SYNC_STAGES  = 2;

    // ----------------------------------------------------------------
    // low address steps per region width
    // ----------------------------------------------------------------
    localparam logic [3:0] STEP_8   = 4'h1;
    localparam logic [3:0] STEP_16  = 4'h2;
    localparam logic [3:0] STEP_32  = 4'h4;

    // ----------------------------------------------------------------
    // pin reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] AD_RST     = 32'h0000_0000;
    localparam logic [3:0]  LO_RST     = 4'h0;
    localparam logic [3:0]  BE_N_RST   = 4'hf;

endpackage : mbap_pkg

// >>> mbap_step_if.sv
`timescale 1ns/10ps
interface mbap_step_if;
    logic       load;
    logic       step;
    logic       park;
    logic [1:0] width;
    logic [3:0] start_lo;
    logic [3:0] req_be_n;
    logic [3:0] lo;
    logic [3:0] be_n;

    modport ctl (output load, output step, output park, output width,
                 output start_lo, output req_be_n, input lo, input be_n);
    modport gen (input load, input step, input park, input width,
                 input start_lo, input req_be_n, output lo, output be_n);
endinterface : mbap_step_if

// >>> mbap_buf2.sv
`timescale 1ns/10ps
module mbap_buf2 (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        in_valid,
    output logic             in_ready,
    input  wire logic [32:0] in_data,
    output logic             out_valid,
    input  wire logic        out_ready,
    output logic [32:0]      out_data
);
    logic [32:0] d1_r;
    logic        v1_r;
    logic        push;
    logic        pop;

    // ----------------------------------------------------------------
    // two entries: head drives the outputs straight from flops
    // ----------------------------------------------------------------
    assign in_ready = !v1_r;
    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;

    // head entry refills from the tail or the input
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            out_valid <= 1'b0;
            out_data  <= 33'h0_0000_0000;
        end else if (!out_valid || pop) begin
            out_valid <= v1_r || push;
            out_data  <= v1_r ? d1_r : in_data;
        end
    end

    // tail entry only fills when the head is stalled
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            v1_r <= 1'b0;
            d1_r <= 33'h0_0000_0000;
        end else if (pop || !out_valid) begin
            v1_r <= v1_r && push && out_valid;
            d1_r <= in_data;
        end else if (push) begin
            v1_r <= 1'b1;
            d1_r <= in_data;
        end
    end
endmodule : mbap_buf2

// >>> mbap_burst_lo.sv
`timescale 1ns/10ps
module mbap_burst_lo (
    input  wire logic mclk,
    input  wire logic rstn,
    mbap_step_if.gen  st
);
    // ----------------------------------------------------------------
    // step size by region width
    // ----------------------------------------------------------------
    function automatic logic [3:0] step_of(input logic [1:0] w);
        case (w)
            mbap_pkg::WIDTH_8:  step_of = mbap_pkg::STEP_8;
            mbap_pkg::WIDTH_16: step_of = mbap_pkg::STEP_16;
            default:            step_of = mbap_pkg::STEP_32;
        endcase
    endfunction : step_of

    // narrow regions borrow byte enable pins for the low address bits
    function automatic logic [3:0] be_of(input logic [1:0] w, input logic [3:0] lo,
                                         input logic [3:0] be);
        case (w)
            mbap_pkg::WIDTH_8:  be_of = {2'h3, lo[1], lo[0]};
            mbap_pkg::WIDTH_16: be_of = {be[3], 1'b1, lo[1], be[0]};
            default:            be_of = be;
        endcase
    endfunction : be_of

    logic [1:0] width_r;
    logic [3:0] be_keep_r;
    logic [3:0] lo_nxt;

    assign lo_nxt = st.lo + step_of(width_r);

    // ----------------------------------------------------------------
    // partial address: loaded in the address cycle, bumped per ready
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st.lo     <= mbap_pkg::LO_RST;
            width_r   <= mbap_pkg::WIDTH_32;
            be_keep_r <= mbap_pkg::BE_N_RST;
        end else if (st.load) begin
            st.lo     <= st.start_lo;
            width_r   <= st.width;
            be_keep_r <= st.req_be_n;
        end else if (st.step) begin
            st.lo     <= lo_nxt;
        end
    end

    // byte enable pins follow the stepping low address in 8/16-bit regions; halt parks them high
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st.be_n <= mbap_pkg::BE_N_RST;
        end else if (st.load) begin
            st.be_n <= be_of(st.width, st.start_lo, st.req_be_n);
        end else if (st.step) begin
            st.be_n <= be_of(width_r, lo_nxt, be_keep_r);
        end else if (st.park) begin
            st.be_n <= mbap_pkg::BE_N_RST;
        end
    end
endmodule : mbap_burst_lo

// >>> mbap_mem_model.sv
`timescale 1ns/10ps
// memory beside the bus: latches the address word, then answers each beat
// with a one-cycle ready pulse; slow mode leaves random gaps between beats
module mbap_mem_model (
    input  wire logic        mclk,
    input  wire logic        slow,
    input  wire logic        access_start_strobe_n,
    input  wire logic        ad_oe_n,
    input  wire logic [31:0] ad_out,
    output logic             ready_recover_n,
    output logic [31:0]      ad_in
);
    logic [31:0] word_r = 32'h0;
    logic [31:0] drv_r  = 32'h0;
    logic [2:0]  left_r = 3'h0;
    logic [1:0]  beat_r = 2'h0;
    initial ready_recover_n = 1'b1;
    // a released bus shows the inverse of its last value, never a stale copy
    always @(posedge mclk) begin
        ready_recover_n <= 1'b1;
        drv_r <= ~drv_r;
        if (!access_start_strobe_n) begin
            word_r <= ad_out;
            left_r <= 3'(ad_out[1:0]) + 3'h1;
            beat_r <= 2'h0;
        end else if (left_r != 3'h0 && (!slow || $urandom_range(2) == 0)) begin
            ready_recover_n <= 1'b0;
            drv_r <= {word_r[31:2], beat_r};
            left_r <= left_r - 3'h1;
            beat_r <= beat_r + 2'h1;
        end
    end
    // wire level: the device wins while its output enable is low
    assign ad_in = ad_oe_n ? drv_r : ad_out;
endmodule : mbap_mem_model

// >>> mbap_bus_properties.sv
`timescale 1ns/10ps
module mbap_bus_chk (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic [31:0] req_addr,
    input wire logic [1:0]  req_size,
    input wire logic        halted,
    input wire logic [31:0] ad_out,
    input wire logic        ad_oe_n,
    input wire logic        addr_latch,
    input wire logic        addr_latch_n,
    input wire logic        access_start_strobe_n,
    input wire logic        strobe_oe_n,
    input wire logic        write_read,
    input wire logic        hold_ack
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic [31:0] exp_ad_r;
    // bus word owed in the cycle after a take
    always_ff @(posedge mclk) exp_ad_r <= {req_addr[31:2], req_size};
    sequence s_take; req_valid && req_ready; endsequence
    sequence s_addr_cyc; addr_latch && !ad_oe_n ##1 !addr_latch; endsequence
    AST_LATCH_INV: assert property (addr_latch_n == !addr_latch)
        else $error("latch strobe pair not inverse");
    AST_START_MATCH: assert property (access_start_strobe_n == !addr_latch)
        else $error("start strobe not aligned to address cycle");
    AST_ONE_ADDR: assert property (s_take |=> s_addr_cyc)
        else $error("address cycle missing or too long");
    AST_ADDR_WORD: assert property (s_take |=> ad_out == exp_ad_r)
        else $error("address word or count code wrong");
    AST_DIR_HELD: assert property (!(req_valid && req_ready) |=> $stable(write_read))
        else $error("direction changed inside an access");
    AST_ACCESS_ENDS: assert property (s_take |=> !req_ready ##[1:600] req_ready)
        else $error("access never completed");
    AST_HOLD_FLOAT: assert property (hold_ack |-> ad_oe_n && strobe_oe_n)
        else $error("pins driven during hold");
    AST_HALT_PINS: assert property (halted && !hold_ack |->
        !addr_latch && access_start_strobe_n && !ad_oe_n)
        else $error("halt pin states wrong");
endmodule : mbap_bus_chk
bind mbap_bus mbap_bus_chk i_chk (.mclk, .rstn, .req_valid, .req_ready, .req_addr,
    .req_size, .halted, .ad_out, .ad_oe_n, .addr_latch, .addr_latch_n,
    .access_start_strobe_n, .strobe_oe_n, .write_read, .hold_ack);

// >>> testbench.sv
`timescale 1ns/10ps
module testbench;
    logic         mclk, rstn, req_valid, req_ready, req_write, halt_req, halted, slow;
    logic         rd_valid, rd_ready, rd_last, ad_oe_n, addr_latch, addr_latch_n;
    logic         access_start_strobe_n, strobe_oe_n, write_read, ready_recover_n;
    logic         hold_req, hold_ack, wait_cycle;
    logic [1:0]   req_size, req_width;
    logic [3:0]   req_be_n, byte_lane_enables_n;
    logic [3:2]   addr_lo;
    logic [31:0]  req_addr, rd_data, ad_out, ad_in;
    logic [127:0] req_wdata;
    logic [32:0]  exp_q[$];
    logic [32:0]  exp_w;
    int           n_fail, tests_run;
    initial mclk = 1'b0;
    // 25 MHz clock
    always #20 mclk = ~mclk;
    mbap_bus i_dut (.mclk, .rstn, .req_valid, .req_ready, .req_addr, .req_write, .req_size,
        .req_width, .req_be_n, .req_wdata, .halt_req, .halted, .rd_valid, .rd_ready, .rd_data,
        .rd_last, .ad_out, .ad_in, .ad_oe_n, .addr_latch, .addr_latch_n, .access_start_strobe_n,
        .strobe_oe_n, .addr_lo, .byte_lane_enables_n, .write_read, .ready_recover_n,
        .hold_req, .hold_ack, .wait_cycle);
    mbap_mem_model i_mem (.mclk, .slow, .access_start_strobe_n, .ad_oe_n, .ad_out,
        .ready_recover_n, .ad_in);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude;
        if (n_fail == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    task automatic settle;
        for (int n = 0; n < 400 && req_ready !== 1'b1; n++) @(negedge mclk);
    endtask : settle
    // one access: the request stands until the edge that takes it
    task automatic access(input logic [31:0] a, input logic w, input logic [1:0] sz,
                          input logic [1:0] wd);
        logic [3:0] be;
        logic [3:0] eb;
        be = 4'($urandom);
        eb = be;
        if (wd == mbap_pkg::WIDTH_16) eb = {be[3], 1'b1, a[1], be[0]};
        if (wd == mbap_pkg::WIDTH_8) eb = {2'b11, a[1:0]};
        settle();
        for (int b = 0; b <= int'(sz); b++) begin
            if (!w) exp_q.push_back({b == int'(sz), a[31:2], 2'(b)});
        end
        req_wdata = {$urandom, $urandom, $urandom, $urandom};
        {req_valid, req_addr, req_write, req_size, req_width, req_be_n} = {1'b1, a, w, sz, wd, be};
        @(posedge mclk);
        @(negedge mclk);
        req_valid = 1'b0;
        chk({addr_latch, addr_latch_n, access_start_strobe_n, ad_oe_n}, 4'h8);
        chk(write_read, w);
        chk(ad_out, {a[31:2], sz});
        chk({addr_lo, byte_lane_enables_n}, {a[3:2], eb});
        @(negedge mclk);
        chk({addr_latch, wait_cycle}, 2'h0);
        @(negedge mclk);
        chk(wait_cycle, 1'b1);
    endtask : access
    // park in halt, check the parked bus, then lend the bus out and take it back
    task automatic halt_chk(input logic [31:0] exp, input logic [31:0] msk);
        settle();
        halt_req = 1'b1;
        for (int n = 0; n < 40 && halted !== 1'b1; n++) @(negedge mclk);
        chk(ad_out & msk, exp);
        chk({halted, addr_latch, access_start_strobe_n, ad_oe_n, byte_lane_enables_n}, 8'haf);
        hold_req = 1'b1;
        for (int n = 0; n < 40 && hold_ack !== 1'b1; n++) @(negedge mclk);
        chk({hold_ack, ad_oe_n, strobe_oe_n}, 3'h7);
        {hold_req, halt_req} = 2'h0;
        settle();
    endtask : halt_chk
    // read words leave in order; each is matched against the oldest note
    always @(posedge mclk) begin
        if (rstn && rd_valid && rd_ready) begin
            exp_w = exp_q.pop_front();
            tests_run++;
            if ({rd_last, rd_data} !== exp_w) begin
                n_fail++;
                $display("Error at %0t: read %h expected %h", $time, {rd_last, rd_data}, exp_w);
            end
        end
    end
    // main sequence, inputs change on the falling edge
    initial begin
        {rstn, req_valid, req_write, halt_req, hold_req, slow, rd_ready} = 7'h01;
        {req_addr, req_size, req_width, req_be_n, req_wdata} = '0;
        n_fail = 0;
        tests_run = 0;
        void'($urandom(72));
        repeat (16) @(negedge mclk);
        chk({addr_latch, addr_latch_n, access_start_strobe_n}, 3'h3);
        rstn = 1'b1;
        // every width and count code twice, direction and pacing at random
        for (int i = 0; i < 24; i++) begin
            slow = 1'($urandom);
            access($urandom, 1'($urandom), 2'(i % 4), 2'(i / 4 % 3));
        end
        // reader stalls: both words must stand until drained
        rd_ready = 1'b0;
        access(32'h0000_1230, 1'b0, mbap_pkg::SIZE_TWO, mbap_pkg::WIDTH_32);
        settle();
        repeat (4) @(negedge mclk);
        chk({rd_valid, req_ready}, 2'h3);
        rd_ready = 1'b1;
        access(32'h8765_4320, 1'b0, mbap_pkg::SIZE_THREE, mbap_pkg::WIDTH_32);
        halt_chk(32'h8765_432a, 32'hffff_ffff);
        access(32'h1357_9bd0, 1'b1, mbap_pkg::SIZE_ONE, mbap_pkg::WIDTH_32);
        halt_chk({req_wdata[31:2], 2'h0}, 32'hffff_ffff);
        repeat (8) @(negedge mclk);
        chk(32'(exp_q.size()), 32'h0);
        conclude();
    end
    // cut a hang short well past the longest expected run
    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        conclude();
    end
endmodule : testbench
